// *** design/dgz_defs.svh ***
// Register offsets, field positions and reset values of the digitizer control bank
`ifndef DGZ_DEFS_SVH
`define DGZ_DEFS_SVH

// ==========================================================
// Register offsets
`define DGZ_REG_REV 8'h00
`define DGZ_REG_DIV_HI 8'h01
`define DGZ_REG_DIV_LO 8'h02
`define DGZ_REG_PLL 8'h03
`define DGZ_REG_PHASE 8'h04
`define DGZ_REG_CLAMP_START 8'h05
`define DGZ_REG_CLAMP_WIDTH 8'h06
`define DGZ_REG_HS_WIDTH 8'h07
`define DGZ_REG_GAIN_B 8'h08
`define DGZ_REG_GAIN_G 8'h09
`define DGZ_REG_GAIN_R 8'h0a
`define DGZ_REG_OFS_B 8'h0b
`define DGZ_REG_OFS_G 8'h0c
`define DGZ_REG_OFS_R 8'h0d

// ==========================================================
// Reset values
`define DGZ_RST_DIV_HI 8'h69
`define DGZ_RST_DIV_LO 8'hd0
`define DGZ_RST_PLL 8'h48
`define DGZ_RST_PHASE 8'h80
`define DGZ_RST_CLAMP_START 8'h80
`define DGZ_RST_CLAMP_WIDTH 8'h80
`define DGZ_RST_HS_WIDTH 8'h20
`define DGZ_RST_GAIN 8'h80
`define DGZ_RST_OFS 8'h80

// ==========================================================
// Field positions
`define DGZ_DIV_LO_MSB 7
`define DGZ_DIV_LO_LSB 4
`define DGZ_VCO_MSB 7
`define DGZ_VCO_LSB 6
`define DGZ_PUMP_MSB 5
`define DGZ_PUMP_LSB 3
`define DGZ_PHASE_MSB 7
`define DGZ_PHASE_LSB 3
`define DGZ_HALVE_BIT 0

// ==========================================================
// Host port address and datapath constants
`define DGZ_DEV_ADDR 7'h5c
`define DGZ_OFS_BIAS 13'sh200
`define DGZ_PIX_MAX 10'h3ff
`define DGZ_PCNT_MAX 9'h1ff

`endif

// *** design/dgz_pkg.sv ***
// Types shared by the digitizer control bank modules
package dgz_pkg;

	// ==========================================================
	// Host port sequencing
	typedef enum logic [2:0] {
		HP_IDLE = 3'b000,
		HP_RX = 3'b001,
		HP_TXACK = 3'b010,
		HP_TX = 3'b011,
		HP_RXACK = 3'b100
	} dgz_hp_e;

	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_SUB = 2'b01,
		PH_DATA = 2'b10
	} dgz_phase_e;

	// ==========================================================
	// Programmed settings; index 0 blue, 1 green, 2 red
	typedef struct packed {
		logic [7:0] div_hi;
		logic [3:0] div_lo;
		logic [1:0] vco;
		logic [2:0] pump;
		logic [4:0] phase;
		logic halve;
		logic [7:0] clamp_start;
		logic [7:0] clamp_width;
		logic [7:0] hs_width;
		logic [2:0][7:0] gain;
		logic [2:0][7:0] offset;
	} dgz_regs_s;

	// ==========================================================
	// Whole state of the top module
	typedef struct packed {
		dgz_hp_e st;
		dgz_phase_e phase;
		logic rw;
		logic [2:0] cnt;
		logic flag;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic sda_oe;
		logic scl_q;
		logic sda_q;
		dgz_regs_s regs;
		dgz_regs_s act;
		logic line_run;
		logic [8:0] pcnt;
		logic clamp_int;
		logic clamp_out;
		logic hs_on;
		logic half_ph;
		logic dclk;
	} dgz_top_s;

	typedef struct packed {
		logic [2:0] ff;
		logic q;
	} dgz_sync_s;

	typedef struct packed {
		logic [9:0] res;
		logic vld;
	} dgz_chan_s;

endpackage : dgz_pkg

// *** design/dgz_pix_if.sv ***
// Per-channel settings and sample path between the control bank and a channel
`timescale 1ns/1ps

interface dgz_pix_if;
	logic [7:0] gain;
	logic [7:0] offset;
	logic [9:0] sample;
	logic valid;
	logic [9:0] result;
	logic res_valid;

	modport ctrl (output gain, output offset, output sample, output valid,
		input result, input res_valid);
	modport chan (input gain, input offset, input sample, input valid,
		output result, output res_valid);
endinterface : dgz_pix_if

// *** design/dgz_sync3.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module dgz_sync3 #(
	parameter logic INIT = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Pin and filtered level
	input wire logic din,
	output logic q
);
	dgz_pkg::dgz_sync_s s;
	dgz_pkg::dgz_sync_s next_s;

	// ==========================================================
	// Shift in; output follows only when stages two and three agree
	always_comb begin
		next_s = s;
		next_s.ff = {s.ff[1:0], din};
		if (s.ff[1] == s.ff[2]) begin
			next_s.q = s.ff[2];
		end
	end

	// State register; first stage feeds only the second
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= {{3{INIT}}, INIT};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;
endmodule : dgz_sync3

// *** design/dgz_chan.sv ***
// One channel of digital fine gain and offset with saturation
`timescale 1ns/1ps
`include "dgz_defs.svh"

module dgz_chan (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Settings, sample in, result out
	dgz_pix_if.chan bus
);
	dgz_pkg::dgz_chan_s s;
	dgz_pkg::dgz_chan_s next_s;
	logic [18:0] prod;
	logic signed [12:0] gained;
	logic signed [12:0] ofs;
	logic signed [12:0] sum;

	// ==========================================================
	// Gain of 1 + code/256, then offset, clipped to the code range
	always_comb begin
		next_s = s;
		prod = bus.sample * {1'b1, bus.gain};
		gained = $signed({2'b00, prod[18:8]});
		// Offset code fills bits 9..2; 80h is the zero point
		ofs = $signed({3'b000, bus.offset, 2'b00}) - `DGZ_OFS_BIAS;
		sum = gained + ofs;
		next_s.vld = bus.valid;
		if (bus.valid) begin
			// Clip rather than wrap, so bright pixels never turn black
			if (sum < 0) begin
				next_s.res = 10'h000;
			end else if (sum > $signed({3'b000, `DGZ_PIX_MAX})) begin
				next_s.res = `DGZ_PIX_MAX;
			end else begin
				next_s.res = sum[9:0];
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign bus.result = s.res;
	assign bus.res_valid = s.vld;
endmodule : dgz_chan

// *** design/dgz_top.sv ***
// Digitizer control bank: serial host port, settings, clamp and line sync timing
//
// Contract
// - Revision register is read-only, eight bits; writes do nothing.
// - Twelve-bit divider from upper byte plus nibble drives PLL feedback.
// - Two-bit oscillator range selects ultra-low, low, medium or high band.
// - Three-bit charge pump code selects loop filter current.
// - Five-bit sampling phase, 32 steps of 11.25 degrees per pixel.
// - Halve bit selects data clock at pixel rate or half rate.
// - Internal clamp starts a programmed number of pixels after line sync.
// - External clamp selection ignores clamp start and uses the clamp pin.
// - Internal clamp lasts the programmed number of pixels.
// - Line sync output lasts the programmed number of pixels, reset 20h.
// - Each channel gain is one plus code over 256.
// - Offset is offset-binary bits 9..2 of a ten-bit offset.
// - Green and red offsets use the same coding as blue.
// - At reset offset, blanking stays at code 0 or 512; the gain still scales 512, to 768 at reset gain 80h.
// - Subaddress advances after every data byte, read or write.
`timescale 1ns/1ps
`include "dgz_defs.svh"

module dgz_top #(
	parameter logic [7:0] REV_ID = 8'h01 // Arbitrary value
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Serial host port pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// PLL controls
	output logic [11:0] pll_divider,
	output logic [1:0] oscillator_range,
	output logic [2:0] pump_current,
	output logic [4:0] sample_phase,
	// Line timing
	input wire logic line_start,
	input wire logic pix_valid,
	input wire logic clamp_ext_select,
	input wire logic clamp_ext_in,
	output logic clamp_out,
	output logic line_sync_output,
	output logic output_data_clock,
	// Pixel data, index 0 blue, 1 green, 2 red
	input wire logic [2:0][9:0] sample_in,
	output logic [2:0][9:0] pix_out,
	output logic pix_out_valid
);
	dgz_pkg::dgz_top_s s;
	dgz_pkg::dgz_top_s next_s;
	logic scl_f;
	logic sda_f;
	logic ext_f;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [7:0] rd_now;
	logic [8:0] clamp_end;

	// ==========================================================
	// Pin synchronisers
	dgz_sync3 #(.INIT(1'b1)) u_sync_scl (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.din(scl_in),
		.q(scl_f)
	);

	dgz_sync3 #(.INIT(1'b1)) u_sync_sda (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.din(sda_in),
		.q(sda_f)
	);

	dgz_sync3 #(.INIT(1'b0)) u_sync_clamp (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.din(clamp_ext_in),
		.q(ext_f)
	);

	// ==========================================================
	// Register read map; reserved bits and unmapped offsets read zero
	function automatic logic [7:0] rd_reg(input dgz_pkg::dgz_regs_s r, input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			`DGZ_REG_REV: d = REV_ID;
			`DGZ_REG_DIV_HI: d = r.div_hi;
			`DGZ_REG_DIV_LO: d = {r.div_lo, 4'h0};
			`DGZ_REG_PLL: d = {r.vco, r.pump, 3'b000};
			`DGZ_REG_PHASE: d = {r.phase, 2'b00, r.halve};
			`DGZ_REG_CLAMP_START: d = r.clamp_start;
			`DGZ_REG_CLAMP_WIDTH: d = r.clamp_width;
			`DGZ_REG_HS_WIDTH: d = r.hs_width;
			`DGZ_REG_GAIN_B: d = r.gain[0];
			`DGZ_REG_GAIN_G: d = r.gain[1];
			`DGZ_REG_GAIN_R: d = r.gain[2];
			`DGZ_REG_OFS_B: d = r.offset[0];
			`DGZ_REG_OFS_G: d = r.offset[1];
			`DGZ_REG_OFS_R: d = r.offset[2];
			default: d = 8'h00;
		endcase
		return d;
	endfunction : rd_reg

	// Register write map; revision and unmapped offsets ignore writes
	function automatic dgz_pkg::dgz_regs_s wr_reg(input dgz_pkg::dgz_regs_s r,
			input logic [7:0] a, input logic [7:0] d);
		dgz_pkg::dgz_regs_s n;
		n = r;
		case (a)
			`DGZ_REG_DIV_HI: n.div_hi = d;
			`DGZ_REG_DIV_LO: n.div_lo = d[`DGZ_DIV_LO_MSB:`DGZ_DIV_LO_LSB];
			`DGZ_REG_PLL: begin
				n.vco = d[`DGZ_VCO_MSB:`DGZ_VCO_LSB];
				n.pump = d[`DGZ_PUMP_MSB:`DGZ_PUMP_LSB];
			end
			`DGZ_REG_PHASE: begin
				n.phase = d[`DGZ_PHASE_MSB:`DGZ_PHASE_LSB];
				n.halve = d[`DGZ_HALVE_BIT];
			end
			`DGZ_REG_CLAMP_START: n.clamp_start = d;
			`DGZ_REG_CLAMP_WIDTH: n.clamp_width = d;
			`DGZ_REG_HS_WIDTH: n.hs_width = d;
			`DGZ_REG_GAIN_B: n.gain[0] = d;
			`DGZ_REG_GAIN_G: n.gain[1] = d;
			`DGZ_REG_GAIN_R: n.gain[2] = d;
			`DGZ_REG_OFS_B: n.offset[0] = d;
			`DGZ_REG_OFS_G: n.offset[1] = d;
			`DGZ_REG_OFS_R: n.offset[2] = d;
			default: n = r;
		endcase
		return n;
	endfunction : wr_reg

	// ==========================================================
	// Bus conditions from the filtered pins
	assign scl_rise = scl_f & ~s.scl_q;
	assign scl_fall = ~scl_f & s.scl_q;
	// Start and stop only ever appear while the clock line is high
	assign start_c = s.scl_q & scl_f & s.sda_q & ~sda_f;
	assign stop_c = s.scl_q & scl_f & ~s.sda_q & sda_f;
	assign rd_now = rd_reg(s.regs, s.ptr);

	// ==========================================================
	// Next state: host port sequencer, then line timing
	always_comb begin
		next_s = s;
		clamp_end = 9'h000;
		next_s.scl_q = scl_f;
		next_s.sda_q = sda_f;
		if (start_c) begin
			// A repeated start keeps the subaddress for a following read
			next_s.st = dgz_pkg::HP_RX;
			next_s.phase = dgz_pkg::PH_ADDR;
			next_s.cnt = 3'd0;
			next_s.flag = 1'b0;
			next_s.sda_oe = 1'b0;
		end else if (stop_c) begin
			next_s.st = dgz_pkg::HP_IDLE;
			next_s.sda_oe = 1'b0;
		end else begin
			unique case (s.st)
				dgz_pkg::HP_IDLE: begin
					next_s.sda_oe = 1'b0;
				end
				dgz_pkg::HP_RX: begin
					if (scl_rise) begin
						next_s.sh = {s.sh[6:0], sda_f};
						next_s.cnt = s.cnt + 3'd1;
						next_s.flag = (s.cnt == 3'd7);
					end else if (scl_fall && s.flag) begin
						// Byte complete: acknowledge it on the low phase
						next_s.flag = 1'b0;
						next_s.st = dgz_pkg::HP_TXACK;
						next_s.sda_oe = 1'b1;
						case (s.phase)
							dgz_pkg::PH_ADDR: begin
								if (s.sh[7:1] == `DGZ_DEV_ADDR) begin
									next_s.rw = s.sh[0];
								end else begin
									next_s.st = dgz_pkg::HP_IDLE;
									next_s.sda_oe = 1'b0;
								end
							end
							dgz_pkg::PH_SUB: next_s.ptr = s.sh;
							default: begin
								next_s.regs = wr_reg(s.regs, s.ptr, s.sh);
								next_s.ptr = s.ptr + 8'h01;
							end
						endcase
					end
				end
				dgz_pkg::HP_TXACK: begin
					if (scl_fall) begin
						next_s.cnt = 3'd0;
						if (s.phase == dgz_pkg::PH_ADDR && s.rw) begin
							next_s.st = dgz_pkg::HP_TX;
							next_s.sh = rd_now;
							next_s.sda_oe = ~rd_now[7];
							next_s.ptr = s.ptr + 8'h01;
						end else begin
							next_s.st = dgz_pkg::HP_RX;
							next_s.sda_oe = 1'b0;
							next_s.phase = (s.phase == dgz_pkg::PH_ADDR) ?
								dgz_pkg::PH_SUB : dgz_pkg::PH_DATA;
						end
					end
				end
				dgz_pkg::HP_TX: begin
					if (scl_fall) begin
						if (s.cnt == 3'd7) begin
							next_s.st = dgz_pkg::HP_RXACK;
							next_s.sda_oe = 1'b0;
						end else begin
							next_s.sh = {s.sh[6:0], 1'b0};
							next_s.sda_oe = ~s.sh[6];
							next_s.cnt = s.cnt + 3'd1;
						end
					end
				end
				dgz_pkg::HP_RXACK: begin
					if (scl_rise) begin
						next_s.flag = ~sda_f;
					end else if (scl_fall) begin
						// Master acknowledge asks for one more byte
						if (s.flag) begin
							next_s.st = dgz_pkg::HP_TX;
							next_s.sh = rd_now;
							next_s.sda_oe = ~rd_now[7];
							next_s.ptr = s.ptr + 8'h01;
							next_s.cnt = 3'd0;
							next_s.flag = 1'b0;
						end else begin
							next_s.st = dgz_pkg::HP_IDLE;
						end
					end
				end
				default: begin
					next_s.st = dgz_pkg::HP_IDLE;
					next_s.sda_oe = 1'b0;
				end
			endcase
		end

		// Settings copy into the pixel path only at the line edge, so no
		// pixel mid-line sees a half-updated gain or timing
		if (line_start) begin
			next_s.act = s.regs;
			next_s.line_run = 1'b1;
			next_s.pcnt = 9'h000;
		end else if (pix_valid && s.pcnt != `DGZ_PCNT_MAX) begin
			next_s.pcnt = s.pcnt + 9'h001;
		end

		// Clamp window in pixels after the line edge
		clamp_end = {1'b0, next_s.act.clamp_start} + {1'b0, next_s.act.clamp_width};
		next_s.clamp_int = next_s.line_run &&
			({1'b0, next_s.act.clamp_start} <= next_s.pcnt) && (next_s.pcnt < clamp_end);
		// External clamp pin overrides the programmed window
		next_s.clamp_out = clamp_ext_select ? ext_f : next_s.clamp_int;
		// Line sync output width in pixels; zero gives no pulse
		next_s.hs_on = next_s.line_run && (next_s.pcnt < {1'b0, next_s.act.hs_width});

		// Data clock: one pulse per pixel, or per second pixel when halved
		next_s.dclk = 1'b0;
		if (pix_valid) begin
			next_s.half_ph = ~s.half_ph;
			next_s.dclk = ~s.act.halve | s.half_ph;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
			s.regs.div_hi <= `DGZ_RST_DIV_HI;
			s.regs.div_lo <= 4'(`DGZ_RST_DIV_LO >> `DGZ_DIV_LO_LSB);
			s.regs.vco <= 2'(`DGZ_RST_PLL >> `DGZ_VCO_LSB);
			s.regs.pump <= 3'(`DGZ_RST_PLL >> `DGZ_PUMP_LSB);
			s.regs.phase <= 5'(`DGZ_RST_PHASE >> `DGZ_PHASE_LSB);
			s.regs.halve <= 1'b0;
			s.regs.clamp_start <= `DGZ_RST_CLAMP_START;
			s.regs.clamp_width <= `DGZ_RST_CLAMP_WIDTH;
			s.regs.hs_width <= `DGZ_RST_HS_WIDTH;
			s.regs.gain <= {3{`DGZ_RST_GAIN}};
			s.regs.offset <= {3{`DGZ_RST_OFS}};
			s.act.clamp_start <= `DGZ_RST_CLAMP_START;
			s.act.clamp_width <= `DGZ_RST_CLAMP_WIDTH;
			s.act.hs_width <= `DGZ_RST_HS_WIDTH;
			s.act.gain <= {3{`DGZ_RST_GAIN}};
			s.act.offset <= {3{`DGZ_RST_OFS}};
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Channels: gain, offset and clipping per colour
	dgz_pix_if ch_if[3] ();

	for (genvar i = 0; i < 3; i++) begin : g_ch
		assign ch_if[i].gain = s.act.gain[i];
		assign ch_if[i].offset = s.act.offset[i];
		assign ch_if[i].sample = sample_in[i];
		assign ch_if[i].valid = pix_valid;
		assign pix_out[i] = ch_if[i].result;

		dgz_chan u_chan (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.bus(ch_if[i].chan)
		);
	end

	// ==========================================================
	// Outputs from flops, sda_out tied low; PLL controls follow the host copy at once
	assign pix_out_valid = ch_if[0].res_valid;
	assign sda_out = 1'b0; // Open drain: only ever pulls low
	assign sda_oe = s.sda_oe;
	assign pll_divider = {s.regs.div_hi, s.regs.div_lo};
	assign oscillator_range = s.regs.vco;
	assign pump_current = s.regs.pump;
	assign sample_phase = s.regs.phase;
	assign clamp_out = s.clamp_out;
	assign line_sync_output = s.hs_on;
	assign output_data_clock = s.dclk;
endmodule : dgz_top

// *** sim/dgz_host.sv ***
// Serial host controller model for the digitizer host port
`timescale 1ns/1ps

module dgz_host (
	// Clock
	input wire logic sys_clk,
	// Bus lines, data line as seen with its pull-up
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	// ==========================================================
	// Line idle state; released data floats high through the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ==========================================================
	// Bit level; half periods stay well above ten system clocks
	task automatic hw(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : hw

	// Start, or repeated start from a low clock
	task automatic start();
		sda_low <= 1'b0;
		hw(6);
		scl <= 1'b1;
		hw(12);
		sda_low <= 1'b1;
		hw(12);
		scl <= 1'b0;
		hw(6);
	endtask : start

	task automatic stop();
		sda_low <= 1'b1;
		hw(6);
		scl <= 1'b1;
		hw(12);
		sda_low <= 1'b0;
		hw(12);
	endtask : stop

	// One clock pulse; data only moves while the clock is low
	task automatic pulse(output logic v);
		hw(6);
		scl <= 1'b1;
		hw(10);
		v = sda_line;
		hw(2);
		scl <= 1'b0;
		hw(6);
	endtask : pulse

	// Byte out, MSB first, returns the acknowledge
	task automatic put(input logic [7:0] b, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			sda_low <= ~b[i];
			pulse(v);
		end
		sda_low <= 1'b0;
		pulse(v);
		ack = ~v;
	endtask : put

	// Byte in; the last byte of a read gets a not-acknowledge
	task automatic get(input logic last, output logic [7:0] b);
		logic v;
		sda_low <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			pulse(v);
			b[i] = v;
		end
		sda_low <= ~last;
		pulse(v);
	endtask : get

	// ==========================================================
	// Whole transfers; counts missing acknowledges on writes
	task automatic wr(input logic [7:0] sub, input logic [7:0] d[$], output int nak);
		logic a;
		nak = 0;
		start();
		put(8'hb8, a);
		nak += int'(!a);
		put(sub, a);
		nak += int'(!a);
		foreach (d[i]) begin
			put(d[i], a);
			nak += int'(!a);
		end
		stop();
	endtask : wr

	task automatic rd(input logic [7:0] sub, input int n, output logic [7:0] q[$]);
		logic a;
		logic [7:0] b;
		q = {};
		start();
		put(8'hb8, a);
		put(sub, a);
		start();
		put(8'hb9, a);
		for (int i = 0; i < n; i++) begin
			get(i == n - 1, b);
			q.push_back(b);
		end
		stop();
	endtask : rd
endmodule : dgz_host

// *** sim/dgz_top_chk.sv ***
// Concurrent checks on the digitizer control bank ports
`timescale 1ns/1ps

module dgz_top_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Host port
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// PLL controls
	input wire logic [11:0] pll_divider,
	input wire logic [1:0] oscillator_range,
	input wire logic [2:0] pump_current,
	input wire logic [4:0] sample_phase,
	// Line timing
	input wire logic line_start,
	input wire logic pix_valid,
	input wire logic clamp_ext_select,
	input wire logic clamp_ext_in,
	input wire logic clamp_out,
	input wire logic line_sync_output,
	input wire logic output_data_clock,
	// Pixel data
	input wire logic [2:0][9:0] sample_in,
	input wire logic [2:0][9:0] pix_out,
	input wire logic pix_out_valid
);
	// ==========================================================
	// One domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// PLL side follows the register image and host writes only
	a_pll_reset_vals: assert property ($rose(arst_n) |->
		pll_divider == 12'h69d && oscillator_range == 2'h1 &&
		pump_current == 3'h1 && sample_phase == 5'h10) else $error("PLL reset image wrong");
	a_div_host_only: assert property ($changed(pll_divider) |->
		!scl_in ##1 $stable(pll_divider) [*8]) else $error("divider moved off a write");
	a_phase_host_only: assert property ($changed(sample_phase) |-> !scl_in)
		else $error("phase moved off a write");
	// Host port only moves data while the serial clock is low
	a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("data line moved with clock high");

	// Pixel answer one cycle after the strobe, held otherwise
	a_pix_answer: assert property (pix_valid |=> pix_out_valid)
		else $error("missing pixel result");
	a_pix_cause: assert property (pix_out_valid |-> $past(pix_valid))
		else $error("pixel result without strobe");
	a_pix_hold: assert property (!pix_out_valid |-> $stable(pix_out))
		else $error("pixel output moved between results");
	a_dclk_cause: assert property (output_data_clock |->
		$past(pix_valid) && !$past(output_data_clock)) else $error("stray data clock");

	// Line sync starts at the line edge and ends on a pixel count
	a_hs_begin: assert property (line_start |-> ##[1:2] line_sync_output)
		else $error("line sync did not start");
	a_hs_end: assert property ($fell(line_sync_output) |->
		$past(pix_valid) || $past(pix_valid, 2)) else $error("line sync ended off a pixel");
	a_ext_clamp: assert property ((clamp_ext_select && $stable(clamp_ext_in)) [*8] |->
		clamp_out == clamp_ext_in) else $error("external clamp not followed");
endmodule : dgz_top_chk

bind dgz_top dgz_top_chk chk (.sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pll_divider(pll_divider),
	.oscillator_range(oscillator_range), .pump_current(pump_current),
	.sample_phase(sample_phase), .line_start(line_start), .pix_valid(pix_valid),
	.clamp_ext_select(clamp_ext_select), .clamp_ext_in(clamp_ext_in),
	.clamp_out(clamp_out), .line_sync_output(line_sync_output),
	.output_data_clock(output_data_clock), .sample_in(sample_in), .pix_out(pix_out),
	.pix_out_valid(pix_out_valid));

// *** sim/test_dgz_top.sv ***
// Self-checking bench for the digitizer control bank
`timescale 1ns/1ps

`define CHK(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
		end \
	end

module test_dgz_top;
	// ==========================================================
	// Signals
	localparam logic [7:0] REV = 8'h5a; // Arbitrary value
	localparam logic [7:0] RST_IMG [15] = '{REV, 8'h69, 8'hd0, 8'h48, 8'h80, 8'h80, 8'h80,
		8'h20, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
	logic sys_clk = 1'b0, arst_n = 1'b0, line_start = 1'b0, pix_valid = 1'b0;
	logic clamp_ext_select = 1'b0, clamp_ext_in = 1'b0;
	logic [2:0][9:0] sample_in = '0;
	logic scl, sda_low, sda_out, sda_oe, sda_line, clamp_out, line_sync_output;
	logic output_data_clock, pix_out_valid, halve_on = 1'b0;
	logic [11:0] pll_divider;
	logic [1:0] oscillator_range;
	logic [2:0] pump_current;
	logic [4:0] sample_phase;
	logic [2:0][9:0] pix_out;
	int n_fail = 0, comparisons = 0, n_pix = 0;

	// Clock and open-drain data line with pull-up
	always #50 sys_clk = ~sys_clk;
	assign sda_line = !(sda_low || (sda_oe && !sda_out));

	dgz_host host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
	dgz_top #(.REV_ID(REV)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .pll_divider(pll_divider),
		.oscillator_range(oscillator_range), .pump_current(pump_current),
		.sample_phase(sample_phase), .line_start(line_start), .pix_valid(pix_valid),
		.clamp_ext_select(clamp_ext_select), .clamp_ext_in(clamp_ext_in),
		.clamp_out(clamp_out), .line_sync_output(line_sync_output),
		.output_data_clock(output_data_clock), .sample_in(sample_in), .pix_out(pix_out),
		.pix_out_valid(pix_out_valid));

	// ==========================================================
	// Helpers; expected pixel is clipped, never wrapped
	function automatic logic [9:0] px(input int s, input int g, input int o);
		int v;
		v = (s * (256 + g)) / 256 + 4 * o - 512;
		v = (v < 0) ? 0 : (v > 1023) ? 1023 : v;
		return v[9:0];
	endfunction : px

	task automatic line();
		@(posedge sys_clk);
		line_start <= 1'b1;
		@(posedge sys_clk);
		line_start <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK(line_sync_output, 1'b1)
	endtask : line

	// One pixel, four cycles apart so every timing output has settled
	task automatic pixel(input logic [2:0][9:0] s, input logic [2:0][9:0] e, input logic hs,
		input logic cl);
		@(posedge sys_clk);
		pix_valid <= 1'b1;
		sample_in <= s;
		@(posedge sys_clk);
		pix_valid <= 1'b0;
		#1;
		// Halving phase toggles on every strobe since reset
		`CHK(output_data_clock, !halve_on || n_pix[0])
		n_pix++;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK(pix_out, e)
		`CHK(line_sync_output, hs)
		`CHK(clamp_out, cl)
	endtask : pixel

	// ==========================================================
	// Scenarios
	task automatic t_reset_regs();
		logic [7:0] q[$];
		logic a;
		host.rd(8'h00, 15, q);
		foreach (q[i]) `CHK(q[i], RST_IMG[i])
		host.start();
		host.put(8'hb4, a);
		host.stop();
		`CHK(a, 1'b0)
	endtask : t_reset_regs

	task automatic t_write_regs();
		logic [7:0] q[$];
		int nak;
		host.wr(8'h00, {8'hff, 8'hab, 8'hc0, 8'hb0, 8'h79}, nak);
		`CHK(pll_divider, 12'habc)
		`CHK(pump_current, 3'h6)
		`CHK(sample_phase, 5'h0f)
		host.rd(8'h00, 5, q);
		`CHK({q[0], q[1], q[2], q[4]}, {REV, 24'habc079})
		for (int c = 0; c < 4; c++) begin
			host.wr(8'h03, {8'(c << 6)}, nak);
			`CHK(oscillator_range, 2'(c))
		end
		host.wr(8'h0d, {8'h80, 8'h55}, nak);
		`CHK(pump_current, 3'h0)
		host.wr(8'h03, {8'h78}, nak);
		`CHK(pump_current, 3'h7)
		host.rd(8'h0e, 1, q);
		`CHK(q[0], 8'h00)
	endtask : t_write_regs

	task automatic t_pixels();
		int nak;
		host.wr(8'h05, {8'h06, 8'h10, 8'h03, 8'h00, 8'hff, 8'h80, 8'h80, 8'h81, 8'h7f}, nak);
		pixel({10'h0, 10'h200, 10'h0}, {10'h0, 10'h300, 10'h0}, 1'b0, 1'b0);
		line();
		halve_on = 1'b1;
		`CHK(clamp_out, 1'b0)
		for (int p = 1; p < 24; p++)
			pixel({10'(p * 3), 10'(1023 - p * 44), 10'(p * 44)},
				{px(p * 3, 128, 127), px(1023 - p * 44, 255, 129), px(p * 44, 0, 128)},
				p < 3, p >= 6 && p < 22);
	endtask : t_pixels

	task automatic t_ext_clamp();
		int nak;
		for (int v = 1; v >= 0; v--) begin
			@(posedge sys_clk);
			clamp_ext_select <= 1'b1;
			clamp_ext_in <= 1'(v);
			repeat (8) @(posedge sys_clk);
			#1;
			`CHK(clamp_out, 1'(v))
		end
		@(posedge sys_clk);
		clamp_ext_select <= 1'b0;
		host.wr(8'h04, {8'h78}, nak);
		halve_on = 1'b0;
		line();
		pixel({3{10'h0}}, {10'h0, 10'h4, 10'h0}, 1'b1, 1'b0);
		pixel({3{10'h0}}, {10'h0, 10'h4, 10'h0}, 1'b1, 1'b0);
	endtask : t_ext_clamp

	// ==========================================================
	// Verdict, main sequence and a watchdog against a hung run
	task automatic give_verdict();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		t_reset_regs();
		t_write_regs();
		t_pixels();
		t_ext_clamp();
		give_verdict();
	end

	initial begin
		#9ms;
		n_fail++;
		give_verdict();
	end
endmodule : test_dgz_top
